// >>> tmr2_ctrl.sv
// Module: interrupt flags, async clock control and prescaler reset control
`timescale 1ns/100ps
module tmr2_ctrl
  import tmr2_pkg::*;
(
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  // CPU register access
  input  wire tmr2_bus_t    bus_i,
  output logic      [7:0]   rdata_o,
  // Core events and status
  input  wire logic [7:0]   counter_value_i,
  input  wire logic         cmp_a_match_i,
  input  wire logic         overflow_i,
  input  wire logic         pwm_mode_i,
  input  wire logic         bottom_turn_i,
  input  wire logic [4:0]   async_done_i,
  input  wire logic         async_psr_done_i,
  // CPU interrupt handshake
  input  wire logic         global_irq_en_i,
  input  wire logic [2:0]   vector_taken_i,
  output logic      [2:0]   irq_o,
  // Compare-B outputs, clock and prescaler controls
  output logic      [7:0]   second_compare_value_o,
  output logic              compare_b_waveform_pin_o,
  output tmr2_clksel_t      clksel_o,
  output logic              xtal_osc_en_o,
  output logic              ext_buf_en_o,
  output logic              async_prescaler_reset_o,
  output logic              shared_prescaler_reset_o
);
  tmr2_state_t s_q, s_d;
  logic [7:0]  a;
  logic        hit_flags, hit_gtctl, cmp_b_match, ovf_evt, async_wr;
  logic [4:0]  busy_set;

  always_comb begin
    s_d = s_q;
    // I/O space address is the data-space offset less 0x20
    a = bus_i.io_space ? 8'(bus_i.addr + TMR2_IO_OFFSET) : bus_i.addr; // RQ9
    hit_flags = (a == TMR2_ADDR_FLAGS); // RQ9
    hit_gtctl = (a == TMR2_ADDR_GTCTL); // RQ9
    cmp_b_match = (counter_value_i == s_q.cmp_b); // RQ1
    ovf_evt = pwm_mode_i ? bottom_turn_i : overflow_i; // RQ8
    async_wr = bus_i.wr && s_q.async_sel;
    busy_set = '0;
    busy_set[TMR2_UB_CNT]  = async_wr && (a == TMR2_ADDR_CNT); // RQ14
    busy_set[TMR2_UB_CMPA] = async_wr && (a == TMR2_ADDR_CMPA); // RQ14
    busy_set[TMR2_UB_CMPB] = async_wr && (a == TMR2_ADDR_CMPB); // RQ14
    busy_set[TMR2_UB_CTLA] = async_wr && (a == TMR2_ADDR_CTLA); // RQ14
    busy_set[TMR2_UB_CTLB] = async_wr && (a == TMR2_ADDR_CTLB); // RQ14
    // Set beats clear so an event in the clearing cycle survives
    s_d.busy = (s_q.busy & ~async_done_i) | busy_set; // RQ14
    begin : flag_upd
      logic [2:0] clr, set;
      clr = vector_taken_i; // RQ5 RQ6 RQ7
      if (bus_i.wr && hit_flags) begin
        clr = clr | bus_i.wdata[2:0]; // RQ20
      end
      set = '0;
      set[TMR2_BIT_CMPB] = cmp_b_match; // RQ5
      set[TMR2_BIT_CMPA] = cmp_a_match_i; // RQ6
      set[TMR2_BIT_OVF]  = ovf_evt; // RQ7
      s_d.flags = (s_q.flags & ~clr) | set;
    end
    if (bus_i.wr && a == TMR2_ADDR_MASK) begin
      s_d.mask = bus_i.wdata[2:0];
    end
    if (bus_i.wr && a == TMR2_ADDR_CMPB) begin
      s_d.cmp_b = bus_i.wdata;
    end
    if (bus_i.wr && a == TMR2_ADDR_ASYNC) begin
      s_d.extclk    = bus_i.wdata[TMR2_BIT_EXTCLK];
      // Counter contents are not protected across this change
      s_d.async_sel = bus_i.wdata[TMR2_BIT_ASYNC]; // RQ12 RQ13
    end
    // Prescaler resets outside sync mode: async one waits for completion while async-select is set, shared one is a pulse
    if (!s_q.sync_hold) begin
      s_d.psr_shr = 1'b0; // RQ19
      if (!s_q.async_sel || async_psr_done_i) begin
        s_d.psr_asy = 1'b0; // RQ18
      end
    end
    if (bus_i.wr && hit_gtctl) begin
      s_d.sync_hold = bus_i.wdata[TMR2_BIT_SYNCHOLD];
      if (bus_i.wdata[TMR2_BIT_SYNCHOLD]) begin
        s_d.psr_asy = bus_i.wdata[TMR2_BIT_PSR_ASY]; // RQ16
        s_d.psr_shr = bus_i.wdata[TMR2_BIT_PSR_SHR]; // RQ16
      end else begin
        // Leaving sync mode releases both together so the timers restart in step;
        // outside sync mode a written one still gives its reset pulse
        s_d.psr_asy = bus_i.wdata[TMR2_BIT_PSR_ASY] && !s_q.sync_hold; // RQ17 RQ18
        s_d.psr_shr = bus_i.wdata[TMR2_BIT_PSR_SHR] && !s_q.sync_hold; // RQ17 RQ19
      end
    end
    s_d.irq[TMR2_BIT_CMPB] = global_irq_en_i && s_d.mask[TMR2_BIT_CMPB]
                             && s_d.flags[TMR2_BIT_CMPB]; // RQ2
    s_d.irq[TMR2_BIT_CMPA] = global_irq_en_i && s_d.mask[TMR2_BIT_CMPA]
                             && s_d.flags[TMR2_BIT_CMPA]; // RQ3
    s_d.irq[TMR2_BIT_OVF]  = global_irq_en_i && s_d.mask[TMR2_BIT_OVF]
                             && s_d.flags[TMR2_BIT_OVF]; // RQ4
    s_d.cmp_b_pin = cmp_b_match; // RQ1
    // Crystal and external buffer are exclusive
    if (!s_d.async_sel) begin
      s_d.clksel = TMR2_SEL_IO; // RQ12
    end else if (s_d.extclk) begin
      s_d.clksel = TMR2_SEL_EXT; // RQ10
    end else begin
      s_d.clksel = TMR2_SEL_XTAL; // RQ10
    end
    s_d.rdata = 8'h00;
    if (bus_i.rd) begin
      case (a)
        TMR2_ADDR_FLAGS: s_d.rdata = {5'h00, s_q.flags};
        TMR2_ADDR_MASK:  s_d.rdata = {5'h00, s_q.mask};
        TMR2_ADDR_CMPB:  s_d.rdata = s_q.cmp_b;
        TMR2_ADDR_ASYNC: s_d.rdata = {1'b0, s_q.extclk, s_q.async_sel, s_q.busy};
        TMR2_ADDR_GTCTL: s_d.rdata = {s_q.sync_hold, 5'h00, s_q.psr_asy, s_q.psr_shr};
        default:         s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o                  = s_q.rdata;
  assign irq_o                    = s_q.irq;
  assign second_compare_value_o   = s_q.cmp_b;
  assign compare_b_waveform_pin_o = s_q.cmp_b_pin;
  assign clksel_o                 = s_q.clksel;
  // One-hot select codes let both enables come straight from a flop bit
  assign xtal_osc_en_o            = s_q.clksel[0]; // RQ10
  assign ext_buf_en_o             = s_q.clksel[1]; // RQ10
  assign async_prescaler_reset_o  = s_q.psr_asy;
  assign shared_prescaler_reset_o = s_q.psr_shr;

  // Assertions
  AST_IRQ_B: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    irq_o[2] |-> (s_q.mask[2] && s_q.flags[2])) else $error("cmp b irq without cause"); // RQ2
  AST_IRQ_A: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    irq_o[1] |-> (s_q.mask[1] && s_q.flags[1])) else $error("cmp a irq without cause"); // RQ3
  AST_IRQ_O: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    irq_o[0] |-> (s_q.mask[0] && s_q.flags[0])) else $error("ovf irq without cause"); // RQ4
  AST_FLAG_B: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (counter_value_i == s_q.cmp_b) |=> s_q.flags[2]) else $error("cmp b flag missed"); // RQ5
  AST_FLAG_A: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    cmp_a_match_i |=> s_q.flags[1]) else $error("cmp a flag missed"); // RQ6
  AST_FLAG_O: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (!pwm_mode_i && overflow_i) |=> s_q.flags[0]) else $error("ovf flag missed"); // RQ7
  AST_PWM_BOT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (pwm_mode_i && bottom_turn_i) |=> s_q.flags[0]) else $error("bottom turn missed"); // RQ8
  AST_W0_KEEP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (bus_i.wr && hit_flags && bus_i.wdata[2:0] == 3'h0 && vector_taken_i == 3'h0)
    |=> ($past(s_q.flags) & ~s_q.flags) == 3'h0) else $error("flag lost on zero"); // RQ20
  AST_BUSY: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    busy_set[4] |=> s_q.busy[4]) else $error("counter busy not set"); // RQ14
  AST_SHR_PULSE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (shared_prescaler_reset_o && !s_q.sync_hold && !(bus_i.wr && hit_gtctl))
    |=> !shared_prescaler_reset_o) else $error("shared reset stuck"); // RQ19
  AST_RELEASE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (bus_i.wr && hit_gtctl && s_q.sync_hold && !bus_i.wdata[7])
    |=> (!shared_prescaler_reset_o && !async_prescaler_reset_o))
    else $error("release failed"); // RQ17
  AST_SHR_SET: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (bus_i.wr && hit_gtctl && bus_i.wdata[0] && !(s_q.sync_hold && !bus_i.wdata[7]))
    |=> shared_prescaler_reset_o) else $error("shared reset not applied"); // RQ19
  AST_PSR_HOLD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (s_q.sync_hold && !(bus_i.wr && hit_gtctl)) |=> $stable(async_prescaler_reset_o))
    else $error("held prescaler reset moved"); // RQ16
  AST_VEC_CLR: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (vector_taken_i[0] && !ovf_evt) |=> !s_q.flags[0]) else $error("ovf flag kept"); // RQ7
  AST_IO_SEL: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !s_q.async_sel |-> (clksel_o == TMR2_SEL_IO)) else $error("io clock not selected"); // RQ12
  AST_OSC: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !(xtal_osc_en_o && s_q.extclk)) else $error("crystal on with ext clock"); // RQ10

  COV_IRQ_B: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) irq_o[2]);
  COV_HOLD: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_q.sync_hold && async_prescaler_reset_o ##1 !s_q.sync_hold);
  COV_BUSY: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) s_q.busy[4] ##1 !s_q.busy[4]);
  COV_SHR: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    shared_prescaler_reset_o && !s_q.sync_hold);
endmodule : tmr2_ctrl

// >>> tmr2_ctrl_tb.sv
// Self-checking testbench of the timer interrupt, async clock and prescaler control
`timescale 1ns/100ps
module tmr2_ctrl_tb;
  import tmr2_pkg::*;
  localparam logic [7:0] UA [5] = '{TMR2_ADDR_CTLB, TMR2_ADDR_CTLA, TMR2_ADDR_CMPB,
                                    TMR2_ADDR_CMPA, TMR2_ADDR_CNT};
  localparam logic [7:0] RA [4] = '{TMR2_ADDR_FLAGS, TMR2_ADDR_GTCTL, TMR2_ADDR_MASK,
                                    TMR2_ADDR_ASYNC};
  logic         sys_clk_i, reset_n_i, gie, pwm, pin, xo, eb, par, psr;
  tmr2_bus_t    bus;
  tmr2_clksel_t cs;
  logic [7:0]   cnt, rd, cmpv, r;
  logic [11:0]  ev;
  logic [2:0]   irq, m;
  int           n_errors, checked;

  // Event word: ovf, cmp A, bottom, psr done, vectors [6:4], busy done [11:7]
  tmr2_ctrl dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus_i(bus), .rdata_o(rd),
    .counter_value_i(cnt), .cmp_a_match_i(ev[1]), .overflow_i(ev[0]), .pwm_mode_i(pwm),
    .bottom_turn_i(ev[2]), .async_done_i(ev[11:7]), .async_psr_done_i(ev[3]),
    .global_irq_en_i(gie), .vector_taken_i(ev[6:4]), .irq_o(irq),
    .second_compare_value_o(cmpv), .compare_b_waveform_pin_o(pin), .clksel_o(cs),
    .xtal_osc_en_o(xo), .ext_buf_en_o(eb), .async_prescaler_reset_o(par),
    .shared_prescaler_reset_o(psr));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [2:0] exp_irq(logic [2:0] f, logic [2:0] k, logic g);
    return f & k & {3{g}};
  endfunction

  task automatic test_done;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // Bus strobes last one sampling edge, then drop
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io = 1'b0);
    @(posedge sys_clk_i);
    bus <= '{1'b1, 1'b0, io, a, d};
    tick(1);
    bus.wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic io = 1'b0);
    @(posedge sys_clk_i);
    bus <= '{1'b0, 1'b1, io, a, 8'h00};
    tick(1);
    bus.rd <= 1'b0;
    chk("read data", e, rd);
  endtask

  task automatic pulse(input logic [11:0] p);
    @(posedge sys_clk_i);
    ev <= p;
    tick(1);
    ev <= '0;
  endtask

  // Hang guard, far above the fewer than two hundred cycles the sequence needs
  initial begin
    #200us;
    n_errors++;
    test_done();
  end

  initial begin
    reset_n_i = 1'b0;
    bus = '0;
    ev = '0;
    gie = 1'b0;
    pwm = 1'b0;
    cnt = 8'hFF;  // Away from the reset compare value so no match fires early
    void'($urandom(32'h4ec2));
    repeat (10) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    foreach (RA[k]) rchk(RA[k], TMR2_RESET_VAL);
    r = 8'($urandom_range(254, 0));
    wr(TMR2_ADDR_CMPB, r);
    chk("compare value", r, cmpv);
    cnt <= r;
    tick(3);
    chk("compare pin", 8'h01, {7'h00, pin});
    cnt <= 8'hFF;
    rchk(TMR2_ADDR_FLAGS, 8'h04);
    pulse(12'h001);
    pulse(12'h002);
    rchk(TMR2_ADDR_FLAGS - TMR2_IO_OFFSET, 8'h07, 1'b1);
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 3'h7 : 3'($urandom);
      gie <= (i == 0) | 1'($urandom);
      wr(TMR2_ADDR_MASK, {5'h00, m});
      tick(1);
      chk("irq", {5'h00, exp_irq(3'h7, m, gie)}, {5'h00, irq});
      rchk(TMR2_ADDR_MASK, {5'h00, m});
    end
    wr(TMR2_ADDR_FLAGS, 8'h00);
    rchk(TMR2_ADDR_FLAGS, 8'h07);
    pulse(12'h020);
    rchk(TMR2_ADDR_FLAGS, 8'h05);
    wr(TMR2_ADDR_FLAGS - TMR2_IO_OFFSET, 8'h01, 1'b1);
    rchk(TMR2_ADDR_FLAGS, 8'h04);
    pulse(12'h040);
    rchk(TMR2_ADDR_FLAGS, 8'h00);
    pwm <= 1'b1;
    pulse(12'h004);
    rchk(TMR2_ADDR_FLAGS, 8'h01);
    pulse(12'h010);
    rchk(TMR2_ADDR_FLAGS, 8'h00);
    wr(TMR2_ADDR_GTCTL, 8'h83);
    tick(3);
    rchk(TMR2_ADDR_GTCTL, 8'h83);
    chk("prescaler resets", 8'h03, {6'h00, par, psr});
    wr(TMR2_ADDR_GTCTL - TMR2_IO_OFFSET, 8'h00, 1'b1);
    rchk(TMR2_ADDR_GTCTL, 8'h00);
    chk("prescaler resets", 8'h00, {6'h00, par, psr});
    wr(TMR2_ADDR_GTCTL, 8'h01);
    chk("shared reset pulse", 8'h01, {7'h00, psr});
    rchk(TMR2_ADDR_GTCTL, 8'h00);
    wr(TMR2_ADDR_GTCTL, 8'h02);
    chk("async reset pulse", 8'h01, {7'h00, par});
    rchk(TMR2_ADDR_GTCTL, 8'h00);
    // External clock bit goes in before async select, as software must
    wr(TMR2_ADDR_ASYNC, 8'h40);
    wr(TMR2_ADDR_ASYNC, 8'h60);
    chk("clock select", {4'h0, TMR2_SEL_EXT, 2'b01}, {4'h0, cs, xo, eb});
    wr(TMR2_ADDR_ASYNC, 8'h20);
    chk("clock select", {4'h0, TMR2_SEL_XTAL, 2'b10}, {4'h0, cs, xo, eb});
    foreach (UA[k]) begin
      wr(UA[k], 8'h5A);
      rchk(TMR2_ADDR_ASYNC, 8'h20 | (8'h01 << k));
      pulse(12'(1 << (k + 7)));
      rchk(TMR2_ADDR_ASYNC, 8'h20);
    end
    wr(TMR2_ADDR_GTCTL, 8'h02);
    rchk(TMR2_ADDR_GTCTL, 8'h02);
    pulse(12'h008);
    rchk(TMR2_ADDR_GTCTL, 8'h00);
    wr(TMR2_ADDR_ASYNC, 8'h00);
    chk("clock select", {4'h0, TMR2_SEL_IO, 2'b00}, {4'h0, cs, xo, eb});
    rchk(8'h55, 8'h00);
    test_done();
  end
endmodule // tmr2_ctrl_tb

// >>> tmr2_pkg.sv
// Package: register map, field positions and shared types of the timer interrupt/async block
// Behaviour
// RQ1: Second compare value is compared continuously with the counter; match raises event or pin.
// RQ2: Compare-B request only with mask bit 2, global enable and compare-B flag.
// RQ3: Compare-A request only with mask bit 1, global enable and compare-A flag.
// RQ4: Overflow request only with mask bit 0, global enable and overflow flag.
// RQ5: Flag bit 2 sets on compare-B match; clears on vector taken or written one.
// RQ6: Flag bit 1 sets on compare-A match; clears on vector taken or written one.
// RQ7: Flag bit 0 sets on overflow; clears on vector taken or written one.
// RQ8: In PWM operation overflow flag sets when counter turns at bottom.
// RQ9: Flag and sync control registers also answer at offset minus 0x20.
// RQ10: External-clock bit with async enables input buffer; crystal runs only when bit zero.
// RQ11: Software sets external-clock bit before selecting asynchronous clocking.
// RQ12: Async-select bit zero clocks from I/O clock, one from the crystal.
// RQ13: Counter, compares and controls may corrupt when async-select changes.
// RQ14: Async writes to the five registers set busy bits 4..0 until transferred.
// RQ15: Software must not write an async register while its busy flag is set.
// RQ16: With sync mode bit 7 set both prescaler-reset bits hold their written value.
// RQ17: Writing sync mode zero clears both prescaler-reset bits together.
// RQ18: Bit 1 resets this prescaler; self-clears, or after async reset, not in sync mode.
// RQ19: Bit 0 resets the shared prescaler; self-clears unless sync mode is set.
// RQ20: Writing zero to a flag bit leaves it unchanged.
package tmr2_pkg;
  localparam logic [7:0] TMR2_ADDR_FLAGS   = 8'h37;
  localparam logic [7:0] TMR2_ADDR_GTCTL   = 8'h43;
  localparam logic [7:0] TMR2_ADDR_MASK    = 8'h70;
  localparam logic [7:0] TMR2_ADDR_CNT     = 8'hB2;
  localparam logic [7:0] TMR2_ADDR_CMPA    = 8'hB3;
  localparam logic [7:0] TMR2_ADDR_CMPB    = 8'hB4;
  localparam logic [7:0] TMR2_ADDR_CTLA    = 8'hB0;
  localparam logic [7:0] TMR2_ADDR_CTLB    = 8'hB1;
  localparam logic [7:0] TMR2_ADDR_ASYNC   = 8'hB6;
  localparam logic [7:0] TMR2_IO_OFFSET    = 8'h20;
  localparam logic [7:0] TMR2_RESET_VAL    = 8'h00;
  localparam int         TMR2_BIT_OVF      = 0;
  localparam int         TMR2_BIT_CMPA     = 1;
  localparam int         TMR2_BIT_CMPB     = 2;
  localparam int         TMR2_BIT_ASYNC    = 5;
  localparam int         TMR2_BIT_EXTCLK   = 6;
  localparam int         TMR2_BIT_SYNCHOLD = 7;
  localparam int         TMR2_BIT_PSR_ASY  = 1;
  localparam int         TMR2_BIT_PSR_SHR  = 0;
  // Busy bit index per async register
  localparam int         TMR2_UB_CTLB      = 0;
  localparam int         TMR2_UB_CTLA      = 1;
  localparam int         TMR2_UB_CMPB      = 2;
  localparam int         TMR2_UB_CMPA      = 3;
  localparam int         TMR2_UB_CNT       = 4;
  localparam logic [7:0] TMR2_BOTTOM       = 8'h00;

  typedef enum logic [1:0] {
    TMR2_SEL_IO   = 2'b00,
    TMR2_SEL_XTAL = 2'b01,
    TMR2_SEL_EXT  = 2'b10
  } tmr2_clksel_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmr2_bus_t;

  typedef struct packed {
    logic [2:0]   mask;
    logic [2:0]   flags;
    logic         sync_hold;
    logic         psr_asy;
    logic         psr_shr;
    logic         extclk;
    logic         async_sel;
    logic [4:0]   busy;
    logic [7:0]   cmp_b;
    logic [7:0]   rdata;
    logic [2:0]   irq;
    logic         cmp_b_pin;
    tmr2_clksel_t clksel;
  } tmr2_state_t;
endpackage : tmr2_pkg
